/* pgp_port_groups.sv */
// apb-mapped gpio logic for the six-pin group and the five-pin debug group
`timescale 1ns/1ns
//
// Contract
// R1: group four has six gpio pins, each able to interrupt
// R2: data register: outputs at 13-8, read-only inputs at 5-0
// R3: enable register: input enables 13-8, output enables 5-0, reset zero
// R4: pull register: direction 13-8, pull enable 5-0, reset zero
// R5: six interrupt flags at 5-0, write one clears, zero keeps
// R6: interrupt control: edge select 13-8, interrupt enable 5-0, reset zero
// R7: per-pin debounce enable at 5-0, off after reset
// R8: per-pin mode select at 5-0: zero gpio, one peripheral function
// R9: two-bit function code per pin at 11-0, reset zero
// R10: function zero routes pins 0-3 to converter sensor b, a, reference, oscillation
// R11: debug group has five pins, mode select resets to 0x07
// R12: debug pin 2 output only, no pull, input bits reserved; debug unit mode still sets pin 2 input enable and feeds debug_unit_in
// R13: debug data: inputs 4-3,1-0, bit 2 zero, outputs read/write
// R14: debug enable: input enables 12-11,9-8, bit 10 reserved rw, outputs 4-0
// R15: debug pull: direction 12-8, enables 4-3,1-0, bits 10 and 2 reserved rw
// R16: debug group has no interrupts, flag word reads zero
// R17: debug function code per pin at 9-0, reset zero
// R18: debug function zero routes pins 0-2 to debug unit, two routes 3-4 to clock
// R19: enabled edge sets flag, optionally debounced; irq while flag and enable
// R20: unused bits read zero, fields reset to listed values
//
// register map, one 16-bit register per aligned 32-bit word:
//   0x00 group four pin data         0x20 debug group pin data
//   0x04 group four io enable        0x24 debug group io enable
//   0x08 group four pull control     0x28 debug group pull control
//   0x0c group four irq flags        0x2c debug group irq flags, reads zero
//   0x10 group four irq control      0x30 debug group mode select
//   0x14 group four debounce enable  0x34 debug group function select
//   0x18 group four mode select
//   0x1c group four function select
//
// bus timing: pready is tied high, so every transfer ends in its first
// access cycle; read data is captured at the setup edge and stands until
// the next read setup, which keeps prdata a flip-flop output
//
// pads are taken as synchronous to pclk, so no metastability stage here;
// a pad change shows in the data register one cycle later and sets a flag
// two cycles later with the filter off
//
// the filter samples on a divided tick: DEB_DIV sets the tick period and
// DEB_SAMPLES the differing samples needed before the filtered level moves;
// limitation: three count bits per pin, so DEB_SAMPLES must stay at most 8
//
// reserved read/write bits of the debug enable and pull registers are held
// in the five-bit fields; the pin mask keeps them away from the pads
//
// peripheral routing by function code:
//   group four pins 0-3, code 0: converter sensor b, sensor a, reference,
//                                 oscillation input
//   group four pins 4-5 and every other code: pad idle
//   debug pins 0-2, code 0: debug unit
//   debug pins 3-4, code 2: clock generator oscillator pins
//   any other debug code: pad idle
//
// edge select zero flags a rising edge, one a falling edge; a flag set in
// the cycle of a write-one clear survives, so no edge is lost
//
// after reset every field is zero except the debug mode select, which keeps
// debug pins 0-2 with the debug unit so a probe can attach at once
//
module pgp_port_groups #(
  parameter int DEB_DIV     = pgp_pkg::DEB_DIV,
  parameter int DEB_SAMPLES = pgp_pkg::DEB_SAMPLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // group four pads
  input  wire logic [5:0]  grp4_pad_in,
  output logic      [5:0]  grp4_pad_out,
  output logic      [5:0]  grp4_pad_oe,
  output logic      [5:0]  grp4_pad_ie,
  output logic      [5:0]  grp4_pull_en,
  output logic      [5:0]  grp4_pull_up,
  output logic             grp4_irq,
  // converter channel one
  input  wire logic [3:0]  rfc_out,
  input  wire logic [3:0]  rfc_oe,
  output logic      [3:0]  rfc_in,
  // debug group pads
  input  wire logic [4:0]  dbg_pad_in,
  output logic      [4:0]  dbg_pad_out,
  output logic      [4:0]  dbg_pad_oe,
  output logic      [4:0]  dbg_pad_ie,
  output logic      [4:0]  dbg_pull_en,
  output logic      [4:0]  dbg_pull_up,
  // debug unit and clock generator pins
  input  wire logic [2:0]  debug_unit_out,
  input  wire logic [2:0]  debug_unit_oe,
  output logic      [2:0]  debug_unit_in,
  input  wire logic [1:0]  clock_generator_out,
  input  wire logic [1:0]  clock_generator_oe,
  output logic      [1:0]  clock_generator_in
);

  // whole block state; one copy computed, one registered
  typedef struct packed {
    // group four registers
    logic [5:0]  grp4_output_level;
    logic [5:0]  grp4_input_level;
    logic [5:0]  grp4_input_enable;
    logic [5:0]  grp4_output_enable;
    logic [5:0]  grp4_pull_direction;
    logic [5:0]  grp4_pull_enable;
    logic [5:0]  grp4_irq_flag;
    logic [5:0]  grp4_edge_select;
    logic [5:0]  grp4_irq_enable;
    logic [5:0]  grp4_debounce_on;
    logic [5:0]  grp4_periph_mode;
    logic [11:0] grp4_function_code;
    // group four filter and edge state
    logic [5:0]  grp4_prev;
    logic [5:0]  grp4_filt;
    logic [17:0] deb_cnt;
    logic [15:0] div_cnt;
    // debug group registers
    logic [4:0]  dbggrp_output_level;
    logic [4:0]  dbggrp_input_level;
    logic [4:0]  dbggrp_input_enable;
    logic [4:0]  dbggrp_output_enable;
    logic [4:0]  dbggrp_pull_direction;
    logic [4:0]  dbggrp_pull_enable;
    logic [4:0]  dbggrp_periph_mode;
    logic [9:0]  dbggrp_function_code;
    // captured read data
    logic [31:0] prdata;
  } pgp_state_t;

  pgp_state_t st_r;
  pgp_state_t st_nxt;

  // two-bit field of a packed function code word
  function automatic logic [1:0] pgp_fn(input logic [11:0] w, input int idx);
    pgp_fn = w[2*idx +: 2];
  endfunction

  // bus qualifiers, gated inputs and edge terms
  logic       wr_acc;
  logic       rd_acc;
  logic [5:0] g4_in_q;
  logic [5:0] g4_rise;
  logic [5:0] g4_fall;
  logic [5:0] g4_hit;
  logic       tick;

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  // zero wait states and no error response
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = st_r.prdata;
  // gated input as seen by the edge logic; disabled inputs read low
  assign g4_in_q = grp4_pad_in & st_r.grp4_input_enable;
  assign tick    = (st_r.div_cnt == 16'(DEB_DIV - 1));
  // edge select: zero rising, one falling
  assign g4_rise = st_r.grp4_filt & ~st_r.grp4_prev;
  assign g4_fall = ~st_r.grp4_filt & st_r.grp4_prev;
  assign g4_hit  = ((g4_rise & ~st_r.grp4_edge_select) | (g4_fall & st_r.grp4_edge_select))
                   & st_r.grp4_input_enable; // R19

  // next-state: bus writes, read mux, input sampling, filter and flags
  always_comb begin
    logic [5:0] clr;
    logic [31:0] rd;
    clr    = 6'h00;
    rd     = 32'h0;
    st_nxt = st_r;
    // input sampling; disabled inputs read zero
    st_nxt.grp4_input_level  = g4_in_q; // R2
    st_nxt.dbggrp_input_level = dbg_pad_in & st_r.dbggrp_input_enable & pgp_pkg::DG_IN_MASK; // R13
    // free-running divider for the debounce tick
    st_nxt.div_cnt = tick ? 16'h0 : st_r.div_cnt + 16'h1;
    // debounce: each pin needs DEB_SAMPLES equal samples before the filtered level moves
    // a glitch shorter than one tick is missed or restarts the count
    for (int i = 0; i < pgp_pkg::PG4_PINS; i++) begin
      if (!st_r.grp4_debounce_on[i]) begin
        st_nxt.grp4_filt[i] = g4_in_q[i]; // R7
        st_nxt.deb_cnt[3*i +: 3] = 3'h0;
      end else if (tick) begin
        if (g4_in_q[i] == st_r.grp4_filt[i]) begin
          st_nxt.deb_cnt[3*i +: 3] = 3'h0;
        end else if (st_r.deb_cnt[3*i +: 3] == 3'(DEB_SAMPLES - 1)) begin
          st_nxt.grp4_filt[i] = g4_in_q[i]; // R19
          st_nxt.deb_cnt[3*i +: 3] = 3'h0;
        end else begin
          st_nxt.deb_cnt[3*i +: 3] = st_r.deb_cnt[3*i +: 3] + 3'h1;
        end
      end
    end
    // previous filtered level for the edge compare
    st_nxt.grp4_prev = st_r.grp4_filt;
    // register writes take effect in the access cycle
    if (wr_acc) begin
      case (paddr)
        // group four
        pgp_pkg::OFS_G4_DATA: st_nxt.grp4_output_level = pwdata[pgp_pkg::HI_LSB +: 6]; // R2
        pgp_pkg::OFS_G4_IOEN: begin
          st_nxt.grp4_input_enable  = pwdata[pgp_pkg::HI_LSB +: 6]; // R3
          st_nxt.grp4_output_enable = pwdata[5:0]; // R3
        end
        pgp_pkg::OFS_G4_PULL: begin
          st_nxt.grp4_pull_direction = pwdata[pgp_pkg::HI_LSB +: 6]; // R4
          st_nxt.grp4_pull_enable    = pwdata[5:0]; // R4
        end
        pgp_pkg::OFS_G4_IRQF: clr = pwdata[5:0]; // R5
        pgp_pkg::OFS_G4_IRQC: begin
          st_nxt.grp4_edge_select = pwdata[pgp_pkg::HI_LSB +: 6]; // R6
          st_nxt.grp4_irq_enable  = pwdata[5:0]; // R6
        end
        pgp_pkg::OFS_G4_DEB:  st_nxt.grp4_debounce_on   = pwdata[5:0]; // R7
        pgp_pkg::OFS_G4_MODE: st_nxt.grp4_periph_mode   = pwdata[5:0]; // R8
        pgp_pkg::OFS_G4_FUNC: st_nxt.grp4_function_code = pwdata[11:0]; // R9
        // debug group
        pgp_pkg::OFS_DG_DATA: st_nxt.dbggrp_output_level = pwdata[pgp_pkg::HI_LSB +: 5]; // R13
        pgp_pkg::OFS_DG_IOEN: begin
          st_nxt.dbggrp_input_enable  = pwdata[pgp_pkg::HI_LSB +: 5]; // R14
          st_nxt.dbggrp_output_enable = pwdata[4:0]; // R14
        end
        pgp_pkg::OFS_DG_PULL: begin
          st_nxt.dbggrp_pull_direction = pwdata[pgp_pkg::HI_LSB +: 5]; // R15
          st_nxt.dbggrp_pull_enable    = pwdata[4:0]; // R15
        end
        pgp_pkg::OFS_DG_MODE: st_nxt.dbggrp_periph_mode   = pwdata[4:0]; // R11
        pgp_pkg::OFS_DG_FUNC: st_nxt.dbggrp_function_code = pwdata[9:0]; // R17
        default: ;
      endcase
    end
    // a new edge in the clearing cycle wins over the clear
    st_nxt.grp4_irq_flag = (st_r.grp4_irq_flag & ~clr) | g4_hit; // R5 R19
    // read data latched in the setup cycle so it stands during access
    case (paddr)
      // group four
      pgp_pkg::OFS_G4_DATA: rd = {18'h0, st_r.grp4_output_level, 2'h0, st_r.grp4_input_level}; // R2 R20
      pgp_pkg::OFS_G4_IOEN: rd = {18'h0, st_r.grp4_input_enable, 2'h0, st_r.grp4_output_enable};
      pgp_pkg::OFS_G4_PULL: rd = {18'h0, st_r.grp4_pull_direction, 2'h0, st_r.grp4_pull_enable};
      pgp_pkg::OFS_G4_IRQF: rd = {26'h0, st_r.grp4_irq_flag};
      pgp_pkg::OFS_G4_IRQC: rd = {18'h0, st_r.grp4_edge_select, 2'h0, st_r.grp4_irq_enable};
      pgp_pkg::OFS_G4_DEB:  rd = {26'h0, st_r.grp4_debounce_on};
      pgp_pkg::OFS_G4_MODE: rd = {26'h0, st_r.grp4_periph_mode};
      pgp_pkg::OFS_G4_FUNC: rd = {20'h0, st_r.grp4_function_code};
      // debug group
      pgp_pkg::OFS_DG_DATA: rd = {19'h0, st_r.dbggrp_output_level, 3'h0, st_r.dbggrp_input_level}; // R13
      pgp_pkg::OFS_DG_IOEN: rd = {19'h0, st_r.dbggrp_input_enable, 3'h0, st_r.dbggrp_output_enable}; // R14
      pgp_pkg::OFS_DG_PULL: rd = {19'h0, st_r.dbggrp_pull_direction, 3'h0, st_r.dbggrp_pull_enable}; // R15
      pgp_pkg::OFS_DG_IRQF: rd = 32'h0; // R16
      pgp_pkg::OFS_DG_MODE: rd = {27'h0, st_r.dbggrp_periph_mode};
      pgp_pkg::OFS_DG_FUNC: rd = {22'h0, st_r.dbggrp_function_code};
      default:              rd = 32'h0; // R20
    endcase
    // capture only on a read setup, so writes leave the last read data
    if (psel && !penable && !pwrite) begin
      st_nxt.prdata = rd;
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0; // R20
      st_r.dbggrp_periph_mode <= pgp_pkg::DG_MODE_RST; // R11
    end else begin
      st_r <= st_nxt;
    end
  end

  // level request; high until software clears the flag or the enable
  assign grp4_irq = |(st_r.grp4_irq_flag & st_r.grp4_irq_enable); // R19

  // group four pad muxing
  always_comb begin
    grp4_pad_out = st_r.grp4_output_level;
    grp4_pad_oe  = st_r.grp4_output_enable;
    grp4_pad_ie  = st_r.grp4_input_enable;
    grp4_pull_en = st_r.grp4_pull_enable; // R4
    grp4_pull_up = st_r.grp4_pull_direction;
    rfc_in       = 4'h0;
    for (int i = 0; i < pgp_pkg::PG4_PINS; i++) begin // R1
      // peripheral mode: park the pad, then hand it to the routed unit
      // pins 4 and 5 have no peripheral at all
      if (st_r.grp4_periph_mode[i]) begin // R8
        grp4_pad_out[i] = 1'b0;
        grp4_pad_oe[i]  = 1'b0; // R10 unassigned functions leave the pin idle
        grp4_pad_ie[i]  = 1'b0;
        grp4_pull_en[i] = 1'b0;
        if (i < 4 && pgp_fn(st_r.grp4_function_code, i) == pgp_pkg::FN0) begin
          grp4_pad_out[i] = rfc_out[i]; // R10
          grp4_pad_oe[i]  = rfc_oe[i];
          grp4_pad_ie[i]  = 1'b1;
          rfc_in[i]       = grp4_pad_in[i];
        end
      end
    end
  end

  // debug group pad muxing; pin 2 has no input or pull in gpio mode
  always_comb begin
    dbg_pad_out        = st_r.dbggrp_output_level;
    dbg_pad_oe         = st_r.dbggrp_output_enable;
    dbg_pad_ie         = st_r.dbggrp_input_enable & pgp_pkg::DG_IN_MASK; // R12
    dbg_pull_en        = st_r.dbggrp_pull_enable & pgp_pkg::DG_IN_MASK; // R12
    dbg_pull_up        = st_r.dbggrp_pull_direction & pgp_pkg::DG_IN_MASK;
    debug_unit_in      = 3'h0;
    clock_generator_in = 2'h0;
    for (int i = 0; i < pgp_pkg::DBG_PINS; i++) begin
      if (st_r.dbggrp_periph_mode[i]) begin
        dbg_pad_out[i] = 1'b0;
        dbg_pad_oe[i]  = 1'b0;
        dbg_pad_ie[i]  = 1'b0;
        dbg_pull_en[i] = 1'b0;
        // unassigned codes leave the pin idle
        if (i < 3 && pgp_fn({2'h0, st_r.dbggrp_function_code}, i) == pgp_pkg::FN0) begin
          dbg_pad_out[i]   = debug_unit_out[i]; // R18
          dbg_pad_oe[i]    = debug_unit_oe[i];
          dbg_pad_ie[i]    = 1'b1;
          debug_unit_in[i] = dbg_pad_in[i];
        end else if (i >= 3 && pgp_fn({2'h0, st_r.dbggrp_function_code}, i) == pgp_pkg::FN2) begin
          dbg_pad_out[i]            = clock_generator_out[i-3]; // R18
          dbg_pad_oe[i]             = clock_generator_oe[i-3];
          dbg_pad_ie[i]             = 1'b1;
          clock_generator_in[i-3]   = dbg_pad_in[i];
        end
      end
    end
  end

endmodule

/* pgp_pkg.sv */
// package: register map, field positions and reset values for the port group block
package pgp_pkg;
  localparam int PG4_PINS = 6;
  localparam int DBG_PINS = 5;
  // byte offsets on the apb bus
  localparam logic [7:0] OFS_G4_DATA   = 8'h00;
  localparam logic [7:0] OFS_G4_IOEN   = 8'h04;
  localparam logic [7:0] OFS_G4_PULL   = 8'h08;
  localparam logic [7:0] OFS_G4_IRQF   = 8'h0c;
  localparam logic [7:0] OFS_G4_IRQC   = 8'h10;
  localparam logic [7:0] OFS_G4_DEB    = 8'h14;
  localparam logic [7:0] OFS_G4_MODE   = 8'h18;
  localparam logic [7:0] OFS_G4_FUNC   = 8'h1c;
  localparam logic [7:0] OFS_DG_DATA   = 8'h20;
  localparam logic [7:0] OFS_DG_IOEN   = 8'h24;
  localparam logic [7:0] OFS_DG_PULL   = 8'h28;
  localparam logic [7:0] OFS_DG_IRQF   = 8'h2c;
  localparam logic [7:0] OFS_DG_MODE   = 8'h30;
  localparam logic [7:0] OFS_DG_FUNC   = 8'h34;
  // field positions: upper half fields start at bit 8
  localparam int HI_LSB = 8;
  // reset value and function codes
  localparam logic [4:0] DG_MODE_RST = 5'h07;
  localparam logic [1:0] FN0 = 2'h0;
  localparam logic [1:0] FN2 = 2'h2;
  // debug group: pin 2 is output only in gpio mode
  localparam logic [4:0] DG_IN_MASK = 5'h1b;
  // debounce: number of stable samples at the slow sampling rate
  localparam int DEB_DIV = 100;
  localparam int DEB_SAMPLES = 4;
endpackage

/* pgp_monitor.sv */
// checker: bus and pad relations of the port group block
`timescale 1ns/1ns
module pgp_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  grp4_pad_oe,
  input wire logic [5:0]  grp4_pad_out,
  input wire logic [5:0]  grp4_pull_en,
  input wire logic        grp4_irq,
  input wire logic [3:0]  rfc_out,
  input wire logic [3:0]  rfc_oe,
  input wire logic [4:0]  dbg_pad_oe,
  input wire logic [2:0]  debug_unit_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr_a;
  logic       rd_a;
  logic [5:0] g4_mode_r;
  logic [1:0] g4_fn0_r;
  logic [8:0] dg_sel_r;
  assign wr_a = psel && penable && pwrite;
  assign rd_a = psel && penable && !pwrite;
  // shadow of the routing fields; pad checks only hold in a known mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g4_mode_r <= 6'h00;
      g4_fn0_r  <= 2'h0;
      dg_sel_r  <= 9'h007;
    end else if (wr_a) begin
      if (paddr == pgp_pkg::OFS_G4_MODE) g4_mode_r <= pwdata[5:0];
      if (paddr == pgp_pkg::OFS_G4_FUNC) g4_fn0_r <= pwdata[1:0];
      if (paddr == pgp_pkg::OFS_DG_MODE) dg_sel_r[2:0] <= pwdata[2:0];
      if (paddr == pgp_pkg::OFS_DG_FUNC) dg_sel_r[8:3] <= pwdata[5:0];
    end
  end
  property p_no_err; psel && penable |-> pready && !pslverr; endproperty
  a_no_err: assert property (p_no_err) else $error("bus error seen");
  property p_dg_irqf; rd_a && paddr == pgp_pkg::OFS_DG_IRQF |-> prdata == 32'h0; endproperty
  a_dg_irqf: assert property (p_dg_irqf) else $error("debug flags not zero");
  property p_dg_bit2; rd_a && paddr == pgp_pkg::OFS_DG_DATA |-> prdata[2] == 1'b0 && prdata[7:5] == 3'h0; endproperty
  a_dg_bit2: assert property (p_dg_bit2) else $error("debug data spare bits set");
  property p_pull; logic [5:0] v;
    (wr_a && paddr == pgp_pkg::OFS_G4_PULL && g4_mode_r == 6'h0, v = pwdata[5:0]) |=> grp4_pull_en == v; endproperty
  a_pull: assert property (p_pull) else $error("pull enable mismatch");
  property p_oe; logic [5:0] v;
    (wr_a && paddr == pgp_pkg::OFS_G4_IOEN && g4_mode_r == 6'h0, v = pwdata[5:0]) |=> grp4_pad_oe == v; endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");
  property p_irq_off; wr_a && paddr == pgp_pkg::OFS_G4_IRQC && pwdata[5:0] == 6'h0 |=> !grp4_irq [*2]; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all enables off");
  property p_rfc; g4_mode_r[0] && g4_fn0_r == 2'h0
    |-> grp4_pad_oe[0] == rfc_oe[0] && (!rfc_oe[0] || grp4_pad_out[0] == rfc_out[0]); endproperty
  a_rfc: assert property (p_rfc) else $error("converter pin not routed");
  property p_dbg; dg_sel_r == 9'h007 |-> dbg_pad_oe[2:0] == debug_unit_oe; endproperty
  a_dbg: assert property (p_dbg) else $error("debug pins not routed");
  c_irq: cover property ($rose(grp4_irq));
  c_rfc: cover property (g4_mode_r[0] && rfc_oe[0]);
  c_clr: cover property (wr_a && paddr == pgp_pkg::OFS_G4_IRQF && pwdata[5:0] != 6'h0);
endmodule
bind pgp_port_groups pgp_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .grp4_pad_oe(grp4_pad_oe),
  .grp4_pad_out(grp4_pad_out), .grp4_pull_en(grp4_pull_en), .grp4_irq(grp4_irq), .rfc_out(rfc_out),
  .rfc_oe(rfc_oe), .dbg_pad_oe(dbg_pad_oe), .debug_unit_oe(debug_unit_oe));

/* pgp_pad_model.sv */
// pad model: resolves each pad from the block, an outside driver and pulls
`timescale 1ns/1ns
module pgp_pad_model #(
  parameter int W = 6
) (
  input  wire logic         pclk,
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] pad_oe,
  input  wire logic [W-1:0] pull_en,
  input  wire logic [W-1:0] pull_up,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pad_in
);
  logic [W-1:0] float_r = '0;
  // a floating pad toggles so a stale level never reads as data
  always_ff @(posedge pclk) float_r <= ~float_r;
  // block drive wins, then the outside driver, then the pull
  always_comb begin
    for (int i = 0; i < W; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pull_en[i] ? pull_up[i] : float_r[i];
  end
endmodule

/* testbench.sv */
// self-checking bench for the port group block
`timescale 1ns/1ns
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, grp4_irq;
  logic [5:0]  g_in, g_out, g_oe, g_ie, g_pe, g_pu;
  logic [5:0]  g_ext = 6'h00;
  logic [4:0]  d_in, d_out, d_oe, d_ie, d_pe, d_pu;
  logic [4:0]  d_ext = 5'h00;
  logic [3:0]  rfc_out = 4'h0, rfc_oe = 4'h0, rfc_in;
  logic [2:0]  du_out = 3'h0, du_oe = 3'h0, du_in;
  logic [1:0]  cg_out = 2'h0, cg_oe = 2'h0, cg_in;
  logic [15:0] msk [15] = '{16'h3f00, 16'h3f3f, 16'h3f3f, 16'h0, 16'h3f3f, 16'h3f, 16'h3f, 16'h0fff,
                            16'h1f00, 16'h1f1f, 16'h1f1f, 16'h0, 16'h1f, 16'h03ff, 16'h0};
  int          num_errors = 0;
  int          cmp_count = 0;
  always #5 pclk = ~pclk;
  // debounce divider shortened so filtering fits in a short run
  pgp_port_groups #(.DEB_DIV(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .grp4_pad_in(g_in),
    .grp4_pad_out(g_out), .grp4_pad_oe(g_oe), .grp4_pad_ie(g_ie), .grp4_pull_en(g_pe), .grp4_pull_up(g_pu),
    .grp4_irq(grp4_irq), .rfc_out(rfc_out), .rfc_oe(rfc_oe), .rfc_in(rfc_in), .dbg_pad_in(d_in),
    .dbg_pad_out(d_out), .dbg_pad_oe(d_oe), .dbg_pad_ie(d_ie), .dbg_pull_en(d_pe), .dbg_pull_up(d_pu),
    .debug_unit_out(du_out), .debug_unit_oe(du_oe), .debug_unit_in(du_in), .clock_generator_out(cg_out),
    .clock_generator_oe(cg_oe), .clock_generator_in(cg_in));
  pgp_pad_model #(.W(6)) g_pads (.pclk(pclk), .pad_out(g_out), .pad_oe(g_oe), .pull_en(g_pe),
    .pull_up(g_pu), .ext_val(g_ext), .ext_en(6'h3f), .pad_in(g_in));
  pgp_pad_model #(.W(5)) d_pads (.pclk(pclk), .pad_out(d_out), .pad_oe(d_oe), .pull_en(d_pe),
    .pull_up(d_pu), .ext_val(d_ext), .ext_en(5'h1b), .pad_in(d_in));
  // one apb transfer; an idle edge after it keeps back-to-back calls clean
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset value, every writable bit, then reset value again; index 14 is unmapped
    for (int i = 0; i < 15; i++) begin
      rdc(8'(4 * i), (i == 12) ? 32'h7 : 32'h0);
      apb(8'(4 * i), 1'b1, 32'hffffffff);
      rdc(8'(4 * i), {16'h0, msk[i]});
      apb(8'(4 * i), 1'b1, (i == 12) ? 32'h7 : 32'h0);
    end
    $display("register map done");
    g_ext <= 6'h2a;
    apb(pgp_pkg::OFS_G4_IOEN, 1'b1, 32'h3f00);
    rdc(pgp_pkg::OFS_G4_DATA, 32'h2a);
    apb(pgp_pkg::OFS_G4_DATA, 1'b1, 32'h1500);
    apb(pgp_pkg::OFS_G4_IOEN, 1'b1, 32'h3f3f);
    rdc(pgp_pkg::OFS_G4_DATA, 32'h1515);
    d_ext <= 5'h1f;
    apb(pgp_pkg::OFS_DG_MODE, 1'b1, 32'h0);
    apb(pgp_pkg::OFS_DG_IOEN, 1'b1, 32'h1f00);
    apb(pgp_pkg::OFS_DG_PULL, 1'b1, 32'h1f1f);
    rdc(pgp_pkg::OFS_DG_DATA, 32'h1b);
    chk(32'({d_ie, d_pe}), 32'h37b);
    $display("pin data done");
    // rising on pins 0 and 1, falling selected on pin 5
    g_ext <= 6'h00;
    apb(pgp_pkg::OFS_G4_IOEN, 1'b1, 32'h3f00);
    apb(pgp_pkg::OFS_G4_IRQF, 1'b1, 32'h3f);
    apb(pgp_pkg::OFS_G4_IRQC, 1'b1, 32'h2021);
    g_ext <= 6'h23;
    repeat (4) @(posedge pclk);
    rdc(pgp_pkg::OFS_G4_IRQF, 32'h03);
    chk(32'(grp4_irq), 32'h1);
    apb(pgp_pkg::OFS_G4_IRQF, 1'b1, 32'h01);
    chk(32'(grp4_irq), 32'h0);
    g_ext <= 6'h03;
    repeat (4) @(posedge pclk);
    rdc(pgp_pkg::OFS_G4_IRQF, 32'h22);
    apb(pgp_pkg::OFS_G4_IRQF, 1'b1, 32'h22);
    rdc(pgp_pkg::OFS_G4_IRQF, 32'h0);
    // one-cycle glitch on filtered pin 3 must not flag, a held level must
    apb(pgp_pkg::OFS_G4_DEB, 1'b1, 32'h08);
    g_ext <= 6'h0b;
    @(posedge pclk);
    g_ext <= 6'h03;
    repeat (30) @(posedge pclk);
    rdc(pgp_pkg::OFS_G4_IRQF, 32'h0);
    g_ext <= 6'h0b;
    repeat (30) @(posedge pclk);
    rdc(pgp_pkg::OFS_G4_IRQF, 32'h08);
    $display("interrupts done");
    apb(pgp_pkg::OFS_G4_IOEN, 1'b1, 32'h3f);
    apb(pgp_pkg::OFS_G4_MODE, 1'b1, 32'h1f);
    rfc_oe <= 4'h5;
    rfc_out <= 4'h1;
    g_ext <= 6'h0a;
    repeat (2) @(posedge pclk);
    chk(32'({g_oe, g_out[2], g_out[0], rfc_in[3], rfc_in[1]}), 32'h257);
    chk(32'(g_ie), 32'h0f);
    apb(pgp_pkg::OFS_DG_MODE, 1'b1, 32'h1f);
    apb(pgp_pkg::OFS_DG_FUNC, 1'b1, 32'h280);
    du_oe <= 3'h2;
    cg_oe <= 2'h1;
    d_ext <= 5'h19;
    repeat (2) @(posedge pclk);
    chk(32'({d_oe, du_in[0], cg_in[1]}), 32'h2b);
    $display("pin routing done");
    conclude();
  end
endmodule
